// ==== shared/hidden_rtc_pkg.sv ====
// Constants, register map and state types of the clock-SRAM host
package hidden_rtc_pkg;

  // ****************************************
  // Pin timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_SETUP_NS = 40;
  localparam int ACCESS_NS = 150;
  localparam int RECOVERY_NS = 40;
  localparam int SYNC_STAGES = 2;
  localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC - 1);
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC - 1);
  localparam logic [7:0] RECOVERY_CNT = 8'(RECOVERY_CYC - 1);

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W = 21;
  localparam int SCRATCH_W = 19;
  localparam int KEY_BITS = 64;
  localparam int CLK_BITS = 64;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam logic [63:0] DEFAULT_KEY = 64'h0123456789ABCDEF;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_SCRATCH = 8'h14;
  localparam logic [7:0] OFS_CLK_LO = 8'h18;
  localparam logic [7:0] OFS_CLK_HI = 8'h1C;
  localparam int CTRL_GO_BIT = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_PFAIL_BIT = 2;
  localparam logic [1:0] CMD_MEM_RD = 2'h0;
  localparam logic [1:0] CMD_MEM_WR = 2'h1;
  localparam logic [1:0] CMD_CLK_RD = 2'h2;
  localparam logic [1:0] CMD_CLK_WR = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [20:0] ADDR_RST = 21'h000000;
  localparam logic [18:0] SCRATCH_RST = 19'h00000;

  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_SETUP = 4'b0010,
    E_STROBE = 4'b0100,
    E_HOLD = 4'b1000
  } eng_st_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_MEM = 5'b00010,
    S_PREP = 5'b00100,
    S_KEY = 5'b01000,
    S_XFER = 5'b10000
  } seq_st_t;

endpackage

// ==== logic/async_cycle_engine.sv ====
// One asynchronous SRAM read or write cycle at the device pins
`timescale 1ns/10ps
module async_cycle_engine
  import hidden_rtc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic start, // Begin one cycle
  input wire logic is_write, // Cycle is a write
  input wire logic [20:0] addr, // Cycle address
  input wire logic [7:0] wdata, // Write byte
  output logic done, // Cycle finished strobe
  output logic [7:0] rdata, // Read byte
  output logic [20:0] byte_address_lines, // Address pins
  output logic ce_n, // Chip select strobe
  output logic oe_n, // Output strobe
  output logic we_n, // Write strobe
  output logic [7:0] dq_out, // Data pins out
  output logic dq_oe, // Data pins driven
  input wire logic [7:0] dq_in // Data pins in
);

  eng_st_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_nxt, ce_nxt, oe_nxt, we_nxt, dq_oe_nxt;
  logic [7:0] rdata_nxt, dout_nxt;
  logic [20:0] addr_nxt;
  logic [7:0] dq_s1_r, dq_s2_r;

  // ****************************************
  // Data pin synchroniser
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ****************************************
  // Cycle sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata;
    addr_nxt = byte_address_lines;
    dout_nxt = dq_out;
    dq_oe_nxt = dq_oe;
    ce_nxt = ce_n;
    oe_nxt = oe_n;
    we_nxt = we_n;
    case (st_r)
      E_IDLE: begin
        if (start) begin
          st_nxt = E_SETUP;
          cnt_nxt = SETUP_CNT;
          wr_nxt = is_write;
          addr_nxt = addr;
          dout_nxt = wdata;
          dq_oe_nxt = is_write;
          ce_nxt = 1'b0;
        end
      end
      E_SETUP: begin
        if (cnt_r == 8'h00) begin
          st_nxt = E_STROBE;
          cnt_nxt = STROBE_CNT;
          if (wr_r) begin
            we_nxt = 1'b0;
          end else begin
            oe_nxt = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      E_STROBE: begin
        if (cnt_r == 8'h00) begin
          st_nxt = E_HOLD;
          cnt_nxt = RECOVERY_CNT;
          ce_nxt = 1'b1;
          oe_nxt = 1'b1;
          we_nxt = 1'b1;
          if (!wr_r) begin
            rdata_nxt = dq_s2_r;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      E_HOLD: begin
        if (cnt_r == 8'h00) begin
          st_nxt = E_IDLE;
          dq_oe_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        st_nxt = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= E_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      byte_address_lines <= 21'h000000;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done <= done_nxt;
      rdata <= rdata_nxt;
      byte_address_lines <= addr_nxt;
      dq_out <= dout_nxt;
      dq_oe <= dq_oe_nxt;
      ce_n <= ce_nxt;
      oe_n <= oe_nxt;
      we_n <= we_nxt;
    end
  end

endmodule

// ==== logic/rtc_sram_host.sv ====
// Host controller for a clock-bearing SRAM, steered over AXI4-Lite
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module rtc_sram_host
  import hidden_rtc_pkg::*;
#(
  parameter logic [63:0] KEY = DEFAULT_KEY // Unlock key, bit 0 first
)
(
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [20:0] byte_address_lines, // Device address pins
  output logic ce_n, // Device chip select
  output logic oe_n, // Device output strobe
  output logic we_n, // Device write strobe
  output logic [7:0] dq_out, // Data pins out
  output logic dq_oe, // Data pins driven by host
  input wire logic [7:0] dq_in, // Data pins in
  input wire logic power_fail_threshold // Supply below threshold
);

  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] cmd_r, cmd_nxt;
  logic [20:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [18:0] scratch_r, scratch_nxt;
  logic refused_r, refused_nxt, go_r, go_nxt;
  logic pf_s1_r, pf_s2_r;
  logic reg_wr, busy;
  logic [31:0] lo_merge, hi_merge, ctl_merge, sc_merge;
  seq_st_t seq_r, seq_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic issued_r, issued_nxt, start_r, start_nxt;
  logic eng_wr_r, eng_wr_nxt;
  logic [20:0] eng_addr_r, eng_addr_nxt;
  logic [7:0] eng_wd_r, eng_wd_nxt, mem_rd_r, mem_rd_nxt;
  logic [63:0] clk_r, clk_nxt;
  logic eng_done;
  logic [7:0] eng_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign reg_wr = aw_have_r && w_have_r && !bvalid_r;
  assign busy = (seq_r != S_IDLE) || go_r;
  assign lo_merge = merge(clk_r[31:0], wdata_r, wstrb_r);
  assign hi_merge = merge(clk_r[63:32], wdata_r, wstrb_r);
  assign ctl_merge = merge({11'h000, addr_r}, wdata_r, wstrb_r);
  assign sc_merge = merge({13'h0000, scratch_r}, wdata_r, wstrb_r);

  // ****************************************
  // Power-fail synchroniser
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pf_s1_r <= 1'b0;
      pf_s2_r <= 1'b0;
    end else begin
      pf_s1_r <= power_fail_threshold;
      pf_s2_r <= pf_s1_r;
    end
  end

  // ****************************************
  // AXI4-Lite slave and software registers
  // ****************************************
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    scratch_nxt = scratch_r;
    refused_nxt = refused_r;
    go_nxt = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
      wready_nxt = 1'b0;
    end
    if (reg_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case ({awaddr_r[7:2], 2'b00})
        OFS_CTRL: begin
          if (wstrb_r[0]) begin
            cmd_nxt = wdata_r[1:0];
          end
          if (wstrb_r[1] && wdata_r[CTRL_GO_BIT]) begin
            if (busy || pf_s2_r) begin
              refused_nxt = 1'b1;
            end else begin
              go_nxt = 1'b1;
            end
          end
        end
        OFS_STATUS: begin
          if (wstrb_r[0] && wdata_r[ST_REFUSED_BIT]) begin
            refused_nxt = 1'b0;
          end
        end
        OFS_ADDR: addr_nxt = ctl_merge[20:0];
        OFS_WDATA: begin
          if (wstrb_r[0]) begin
            wdat_nxt = wdata_r[7:0];
          end
        end
        // scratch limited to low 512 kB
        OFS_SCRATCH: begin
          scratch_nxt = sc_merge[18:0];
        end
        OFS_RDATA, OFS_CLK_LO, OFS_CLK_HI: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL: rdata_nxt = {30'h00000000, cmd_r};
        OFS_STATUS: rdata_nxt = {29'h00000000, pf_s2_r, refused_r, busy};
        OFS_ADDR: rdata_nxt = {11'h000, addr_r};
        OFS_WDATA: rdata_nxt = {24'h000000, wdat_r};
        OFS_RDATA: rdata_nxt = {24'h000000, mem_rd_r};
        OFS_SCRATCH: rdata_nxt = {13'h0000, scratch_r};
        OFS_CLK_LO: rdata_nxt = clk_r[31:0];
        OFS_CLK_HI: rdata_nxt = clk_r[63:32];
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h00000000;
      cmd_r <= CMD_MEM_RD;
      addr_r <= ADDR_RST;
      wdat_r <= 8'h00;
      scratch_r <= SCRATCH_RST;
      refused_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      scratch_r <= scratch_nxt;
      refused_r <= refused_nxt;
      go_r <= go_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ****************************************
  // Command sequencer
  // ****************************************
  always_comb begin
    seq_nxt = seq_r;
    idx_nxt = idx_r;
    issued_nxt = issued_r;
    start_nxt = 1'b0;
    eng_wr_nxt = eng_wr_r;
    eng_addr_nxt = eng_addr_r;
    eng_wd_nxt = eng_wd_r;
    mem_rd_nxt = mem_rd_r;
    clk_nxt = clk_r;
    if (seq_r == S_IDLE && reg_wr) begin
      if ({awaddr_r[7:2], 2'b00} == OFS_CLK_LO) begin
        clk_nxt[31:0] = lo_merge;
      end
      if ({awaddr_r[7:2], 2'b00} == OFS_CLK_HI) begin
        clk_nxt[63:32] = hi_merge;
      end
    end
    if (seq_r != S_IDLE && !issued_r) begin
      start_nxt = 1'b1;
      issued_nxt = 1'b1;
    end
    if (eng_done) begin
      issued_nxt = 1'b0;
    end
    case (seq_r)
      S_IDLE: begin
        idx_nxt = 6'h00;
        issued_nxt = 1'b0;
        if (go_r) begin
          if (cmd_r == CMD_MEM_RD || cmd_r == CMD_MEM_WR) begin
            seq_nxt = S_MEM;
          end else begin
            seq_nxt = S_PREP;
          end
        end
      end
      S_MEM: begin
        // full 21-bit address for memory cycles
        eng_wr_nxt = (cmd_r == CMD_MEM_WR);
        eng_addr_nxt = addr_r;
        eng_wd_nxt = wdat_r;
        if (eng_done) begin
          if (cmd_r == CMD_MEM_RD) begin
            mem_rd_nxt = eng_rdata;
          end
          seq_nxt = S_IDLE;
        end
      end
      S_PREP: begin
        eng_wr_nxt = 1'b0;
        eng_addr_nxt = {2'b00, scratch_r};
        if (eng_done) begin
          seq_nxt = S_KEY;
        end
      end
      S_KEY: begin
        eng_wr_nxt = 1'b1;
        eng_addr_nxt = {2'b00, scratch_r};
        eng_wd_nxt = {7'h00, KEY[idx_r]};
        // 64 key writes, no reads between
        if (eng_done) begin
          idx_nxt = idx_r + 6'h01;
          if (idx_r == LAST_BIT) begin
            seq_nxt = S_XFER;
          end
        end
      end
      S_XFER: begin
        eng_wr_nxt = (cmd_r == CMD_CLK_WR);
        eng_addr_nxt = {2'b00, scratch_r};
        eng_wd_nxt = {7'h00, clk_r[idx_r]};
        if (eng_done) begin
          if (cmd_r == CMD_CLK_RD) begin
            clk_nxt[idx_r] = eng_rdata[0];
          end
          idx_nxt = idx_r + 6'h01;
          if (idx_r == LAST_BIT) begin
            seq_nxt = S_IDLE;
          end
        end
      end
      default: begin
        seq_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_r <= S_IDLE;
      idx_r <= 6'h00;
      issued_r <= 1'b0;
      start_r <= 1'b0;
      eng_wr_r <= 1'b0;
      eng_addr_r <= 21'h000000;
      eng_wd_r <= 8'h00;
      mem_rd_r <= 8'h00;
      clk_r <= 64'h0000000000000000;
    end else begin
      seq_r <= seq_nxt;
      idx_r <= idx_nxt;
      issued_r <= issued_nxt;
      start_r <= start_nxt;
      eng_wr_r <= eng_wr_nxt;
      eng_addr_r <= eng_addr_nxt;
      eng_wd_r <= eng_wd_nxt;
      mem_rd_r <= mem_rd_nxt;
      clk_r <= clk_nxt;
    end
  end

  // ****************************************
  // Pin cycle engine
  // ****************************************
  async_cycle_engine u_engine (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(start_r),
    .is_write(eng_wr_r),
    .addr(eng_addr_r),
    .wdata(eng_wd_r),
    .done(eng_done),
    .rdata(eng_rdata),
    .byte_address_lines(byte_address_lines),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dq_in(dq_in)
  );

endmodule

// ==== tb/rtc_sram_host_props.sv ====
// Pin and bus checks for the clock-SRAM host
`timescale 1ns/10ps
module rtc_sram_host_props (
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [20:0] byte_address_lines, // Address
  input wire logic ce_n, // Select
  input wire logic oe_n, // Output strobe
  input wire logic we_n, // Write strobe
  input wire logic [7:0] dq_out, // Data out
  input wire logic dq_oe // Data driven
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_we_width: assert property ($fell(we_n) |-> !we_n[*6] ##1 we_n)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(oe_n) |-> !oe_n[*6] ##1 oe_n)
    else $error("output strobe width wrong");
  a_addr_held: assert property (
    !ce_n && !$past(ce_n) |-> $stable(byte_address_lines))
    else $error("address moved in cycle");
  a_setup_first: assert property ($fell(ce_n) |-> we_n && oe_n)
    else $error("strobe without setup");
  a_we_recover: assert property ($rose(we_n) |-> ce_n ##1 ce_n)
    else $error("recovery too short");
  a_no_contend: assert property (!oe_n |-> !dq_oe)
    else $error("data driven during read");
  a_oe_off_wr: assert property (!we_n |-> oe_n && dq_oe)
    else $error("output strobe low in write");
  a_wdata_held: assert property (!we_n |-> $stable(dq_out))
    else $error("write data moved");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write response repeated");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read response repeated");
endmodule

// ==== tb/rtc_dev_model.sv ====
// Behavioural clock-SRAM device at the far side of the host
`timescale 1ns/10ps
module rtc_dev_model #(
  parameter logic [63:0] KEY = 64'h0 // Unlock key
) (
  input wire logic [20:0] addr, // Address
  input wire logic ce_n, // Select
  input wire logic oe_n, // Output strobe
  input wire logic we_n, // Write strobe
  input wire logic [7:0] dq_wr, // Bus level
  input wire logic pfail, // Power fail
  output logic [7:0] dq_rd // Device data
);
  logic [7:0] mem [int];
  logic [63:0] img;
  logic [7:0] last = 8'h00;
  logic [7:0] dv;
  int ptr = 0;
  int nx = 0;
  bit dead = 1;
  bit unl = 0;
  wire rd_act = !ce_n && !oe_n && we_n;
  wire wr_act = !ce_n && !we_n;
  always @* begin
    dv = mem.exists(addr) ? mem[addr] : 8'h00;
    if (unl) dv = {7'h00, img[nx]};
    dq_rd = (rd_act && !pfail) ? dv : ~last;
  end
  always @(negedge wr_act) begin
    if ((we_n | ce_n) === 1'b1 && !pfail) begin
      if (unl) begin
        img[nx] = dq_wr[0];
        nx++;
        unl = (nx < 64);
      end else begin
        mem[addr] = dq_wr;
        if (!dead && addr < 21'h80000) begin
          if (dq_wr[0] === KEY[ptr]) ptr++;
          else dead = 1;
          if (ptr == 64) begin
            unl = 1;
            nx = 0;
            dead = 1;
          end
        end
      end
    end
  end
  always @(negedge rd_act) begin
    if ((oe_n | ce_n) === 1'b1 && !pfail) begin
      last = dv;
      if (unl) begin
        nx++;
        unl = (nx < 64);
      end else begin
        ptr = 0;
        dead = 0;
      end
    end
  end
endmodule

// ==== tb/tb_rtc_sram_host.sv ====
// Self-checking bench for the clock-SRAM host
`timescale 1ns/10ps
module tb_rtc_sram_host
  import hidden_rtc_pkg::*;
;
  logic sys_clk = '0, arst_n = '0, pfail = '0;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rv;
  logic [3:0] wstrb = 4'hF;
  wire awready, wready, bvalid, arready, rvalid, oe_n, we_n, ce_n, dq_oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] addr;
  wire [7:0] dq_out, dq_rd;
  wire [7:0] bus = dq_oe ? dq_out : dq_rd;
  int failures = 0, num_checks = 0, seed = 54182, i;
  logic [34:0] e;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [20:0] ad [3];
  logic [7:0] dv [3];
  logic [18:0] sc;
  logic [63:0] cv;
  rtc_sram_host u_rtc_sram_host (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .byte_address_lines(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(bus),
    .power_fail_threshold(pfail));
  rtc_dev_model #(.KEY(DEFAULT_KEY)) u_rtc_dev_model (.addr(addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_wr(bus), .pfail(pfail),
    .dq_rd(dq_rd));
  always #20 sys_clk = ~sys_clk;
  task automatic cmp(input logic [33:0] exp, input logic [33:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****
  // Bus master
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r, input logic c);
    rq.push_back({c, r, x});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rready <= 1'b0;
  endtask
  task automatic go(input logic [1:0] cmd);
    wr(OFS_CTRL, 32'h00000100 | 32'(cmd), RESP_OKAY);
    rv = 32'h00000001;
    while (rv[ST_BUSY_BIT]) rd(OFS_STATUS, '0, RESP_OKAY, 1'b0);
  endtask
  always @(posedge sys_clk) begin
    if (rvalid && rready && rq.size() > 0) begin
      e = rq.pop_front();
      if (e[34]) cmp(e[33:0], {rresp, rdata});
    end
    if (bvalid && bready && bq.size() > 0) cmp(34'(bq.pop_front()),
      34'(bresp));
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(OFS_STATUS, '0, RESP_OKAY, 1'b1);
    rd(OFS_SCRATCH, '0, RESP_OKAY, 1'b1);
    rd(8'h20, '0, RESP_SLVERR, 1'b1);
    wr(8'h24, '1, RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      ad[i] = 21'($random(seed));
      dv[i] = 8'($random(seed));
      wr(OFS_ADDR, 32'(ad[i]), RESP_OKAY);
      wr(OFS_WDATA, 32'(dv[i]), RESP_OKAY);
      go(CMD_MEM_WR);
    end
    for (i = 0; i < 3; i++) begin
      wr(OFS_ADDR, 32'(ad[i]), RESP_OKAY);
      go(CMD_MEM_RD);
      rd(OFS_RDATA, 32'(dv[i]), RESP_OKAY, 1'b1);
    end
    sc = 19'($random(seed));
    cv = {$random(seed), $random(seed)};
    wr(OFS_SCRATCH, 32'(sc), RESP_OKAY);
    wr(OFS_CLK_LO, cv[31:0], RESP_OKAY);
    wr(OFS_CLK_HI, cv[63:32], RESP_OKAY);
    go(CMD_CLK_WR);
    u_rtc_dev_model.img[0] = ~u_rtc_dev_model.img[0];
    go(CMD_CLK_RD);
    rd(OFS_CLK_LO, cv[31:0] ^ 32'h1, RESP_OKAY, 1'b1);
    rd(OFS_CLK_HI, cv[63:32], RESP_OKAY, 1'b1);
    wr(OFS_ADDR, 32'(sc), RESP_OKAY);
    go(CMD_MEM_RD);
    rd(OFS_RDATA, 32'(DEFAULT_KEY[63]), RESP_OKAY, 1'b1);
    pfail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    go(CMD_MEM_WR);
    rd(OFS_STATUS, 32'h00000006, RESP_OKAY, 1'b1);
    pfail <= 1'b0;
    wr(OFS_STATUS, 32'h00000002, RESP_OKAY);
    wr(OFS_CTRL, 32'h00000101, RESP_OKAY);
    go(CMD_MEM_WR);
    rd(OFS_STATUS, 32'h00000002, RESP_OKAY, 1'b1);
    rd(OFS_CTRL, 32'h00000001, RESP_OKAY, 1'b1);
    wstrb <= 4'h1;
    wr(OFS_ADDR, 32'hFFFFFFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_ADDR, 32'({sc[18:8], 8'hFF}), RESP_OKAY, 1'b1);
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
endmodule
bind rtc_sram_host rtc_sram_host_props u_props (.sys_clk(sys_clk),
  .arst_n(arst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .byte_address_lines(byte_address_lines),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe));
